//--- hdl/cidsp_top.sv
// Serial output and status logic of the caller-identity receiver.
`timescale 1ns/100ps
module cidsp_top
  import cidsp_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic shift_clk_in,
  // Demodulator and tone detector, ref_clk domain
  input wire cidsp_demod_type demod,
  input wire cidsp_tone_type tone,
  // Control pins
  input wire logic mode_sel,
  input wire logic power_down,
  input wire logic demod_enable,
  input wire logic event_sense_input,
  // Serial port
  output logic serial_shift_clock_o,
  output logic serial_shift_clock_oe_n,
  output logic serial_data,
  output logic data_ready_n,
  // Status
  output logic carrier_present_n,
  output logic raw_tone_flag,
  output logic qualified_tone_flag,
  output logic event_sense_out_n,
  output logic event_request_o,
  output logic event_request_oe_n
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] mode_s_q, pd_s_q, en_s_q, ev_s_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mode_s_q <= 2'h0;
      pd_s_q <= 2'h0;
      en_s_q <= 2'h0;
      ev_s_q <= 2'h0;
    end else begin
      mode_s_q <= {mode_s_q[0], mode_sel};
      pd_s_q <= {pd_s_q[0], power_down};
      en_s_q <= {en_s_q[0], demod_enable};
      ev_s_q <= {ev_s_q[0], event_sense_input};
    end
  end
  logic mode1, active;
  assign mode1 = mode_s_q[1];
  assign active = !pd_s_q[1] && en_s_q[1];

  // ---------------------------------------------------------------------------
  // Event sense with minimum hold
  // ---------------------------------------------------------------------------
  // Hysteresis is done by the pin's Schmitt buffer; here only the hold applies.
  logic ev_q;
  logic [31:0] hold_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ev_q <= 1'b0;
      hold_q <= 32'h0;
    end else if (ev_s_q[1]) begin
      ev_q <= 1'b1;
      hold_q <= HOLD_CYCLES;
    end else if (hold_q != 32'h0) begin
      hold_q <= hold_q - 32'h1;
    end else begin
      ev_q <= 1'b0;
    end
  end
  assign event_sense_out_n = !ev_q;

  // ---------------------------------------------------------------------------
  // Tone and carrier flags
  // ---------------------------------------------------------------------------
  logic raw_q, qual_q, car_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      raw_q <= 1'b0;
      qual_q <= 1'b0;
      car_q <= 1'b0;
    end else begin
      raw_q <= tone.raw_tone && !pd_s_q[1];
      qual_q <= tone.guard_above && !pd_s_q[1];
      car_q <= demod.carrier && active;
    end
  end
  assign raw_tone_flag = raw_q;
  assign qualified_tone_flag = qual_q;
  assign carrier_present_n = !car_q;

  // ---------------------------------------------------------------------------
  // Word assembly from the 1200 baud demodulator
  // ---------------------------------------------------------------------------
  logic [7:0] sr_q, word_q;
  logic [3:0] cnt_q;
  logic word_tgl_q, data0_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !active) begin
      sr_q <= WORD_RST;
      word_q <= WORD_RST;
      cnt_q <= BIT_CNT_RST;
      word_tgl_q <= 1'b0;
      data0_q <= 1'b0;
    end else if (demod.bit_valid) begin
      data0_q <= demod.bit_value;
      sr_q <= {demod.bit_value, sr_q[7:1]};
      if (cnt_q == 4'(WORD_BITS - 1)) begin
        cnt_q <= BIT_CNT_RST;
        word_q <= {demod.bit_value, sr_q[7:1]};
        word_tgl_q <= !word_tgl_q;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Mode 0: device-driven shift clock, one pulse per demodulated bit
  // ---------------------------------------------------------------------------
  cidsp_clk_state_type st_q;
  logic [15:0] div_q;
  logic clk0_q, last0_q, rdy0_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !active || mode1) begin
      st_q <= CIDSP_IDLE;
      div_q <= DIV_RST;
      clk0_q <= 1'b0;
      last0_q <= 1'b0;
      rdy0_q <= 1'b0;
    end else begin
      case (st_q)
        CIDSP_IDLE: begin
          if (demod.bit_valid) begin
            st_q <= CIDSP_HIGH;
            clk0_q <= 1'b1;
            rdy0_q <= 1'b0;
            last0_q <= (cnt_q == 4'(WORD_BITS - 1));
            div_q <= DIV_RST;
          end
        end
        CIDSP_HIGH: begin
          div_q <= div_q + 16'h1;
          if (div_q == HALF_BIT) begin
            st_q <= CIDSP_LOW;
            clk0_q <= 1'b0;
            rdy0_q <= last0_q;
          end
        end
        CIDSP_LOW: st_q <= CIDSP_IDLE;
        default: st_q <= CIDSP_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Mode 1 handshake: acknowledge toggle crosses back from the shift clock domain
  // ---------------------------------------------------------------------------
  logic [2:0] tgl_s_q;
  logic ack_tgl_q;
  logic [1:0] ack_s_q;
  logic ack_seen_q, rdy1_q;
  logic [7:0] hold_word_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !active || !mode1) begin
      tgl_s_q <= 3'h0;
      ack_s_q <= 2'h0;
      ack_seen_q <= 1'b0;
      rdy1_q <= 1'b0;
      hold_word_q <= WORD_RST;
    end else begin
      tgl_s_q <= {tgl_s_q[1:0], word_tgl_q};
      ack_s_q <= {ack_s_q[0], ack_tgl_q};
      ack_seen_q <= ack_s_q[1];
      if (tgl_s_q[2] != tgl_s_q[1]) begin
        rdy1_q <= 1'b1;
        hold_word_q <= word_q;
      end else if (ack_s_q[1] != ack_seen_q) begin
        rdy1_q <= 1'b0;
      end
    end
  end

  // Shift clock domain: word is stable while ready is low, so it is sampled.
  logic [2:0] bit_q;
  logic dout1_q;
  always_ff @(posedge shift_clk_in) begin
    if (!rst_b) begin
      bit_q <= 3'h0;
      ack_tgl_q <= 1'b0;
      dout1_q <= 1'b0;
    end else begin
      dout1_q <= hold_word_q[bit_q];
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        ack_tgl_q <= !ack_tgl_q;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  logic rdy;
  assign rdy = mode1 ? rdy1_q : rdy0_q;
  assign data_ready_n = !rdy;
  assign serial_shift_clock_o = clk0_q;
  assign serial_shift_clock_oe_n = mode1;
  assign serial_data = mode1 ? dout1_q : data0_q;
  assign event_request_o = 1'b0;
  // Asserted while any source is active, so it releases only when all are idle.
  assign event_request_oe_n = !(ev_q || rdy || qual_q);

endmodule // cidsp_top

//--- include/cidsp_pkg.sv
// Package of constants and carriers for the caller-identity serial and status port.
package cidsp_pkg;

  // ---------------------------------------------------------------------------
  // Timing and sizes
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BAUD = 1200;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
  localparam int unsigned HOLD_CYCLES_DEF = 20000;
  localparam int unsigned WORD_BITS = 8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [7:0] WORD_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [15:0] HALF_BIT = 16'(BIT_CYCLES / 2);
  localparam logic [15:0] FULL_BIT = 16'(BIT_CYCLES - 1);

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic carrier;
    logic bit_valid;
    logic bit_value;
  } cidsp_demod_type;

  typedef struct packed {
    logic raw_tone;
    logic guard_above;
  } cidsp_tone_type;

  typedef enum logic [1:0] {
    CIDSP_IDLE,
    CIDSP_HIGH,
    CIDSP_LOW
  } cidsp_clk_state_type;

endpackage

//--- verif/cidsp_checker.sv
// Port assertions for the serial and status port.
`timescale 1ns/100ps
module cidsp_checker
  import cidsp_pkg::*;
#(parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF) (
  // Inputs of the block
  input wire logic ref_clk, rst_b, shift_clk_in, mode_sel, power_down, demod_enable, event_sense_input,
  input wire cidsp_demod_type demod,
  input wire cidsp_tone_type tone,
  // Outputs of the block
  input wire logic serial_shift_clock_o, serial_shift_clock_oe_n, serial_data, data_ready_n,
  input wire logic carrier_present_n, raw_tone_flag, qualified_tone_flag, event_sense_out_n,
  input wire logic event_request_o, event_request_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [31:0] low_q;
  logic idle;
  assign idle = event_sense_out_n && data_ready_n && !qualified_tone_flag;
  // Counts how long the event output has been low, to check its minimum hold.
  always_ff @(posedge ref_clk) begin
    low_q <= (!rst_b || event_sense_out_n) ? 32'h0 : low_q + 32'h1;
  end
  AST_REQ_SET: assert property (!idle |-> ##[0:2] !event_request_oe_n) else $error("request not pulled");
  AST_REQ_REL: assert property ($rose(event_request_oe_n) |-> idle || $past(idle)) else $error("early release");
  AST_REQ_FREE: assert property (idle[*3] |-> event_request_oe_n) else $error("request stuck low");
  AST_MODE: assert property (($stable(mode_sel) && !power_down)[*4] |-> serial_shift_clock_oe_n == mode_sel)
    else $error("clock pin direction wrong");
  AST_QUAL_ON: assert property ((tone.guard_above && !power_down)[*4] |-> qualified_tone_flag)
    else $error("qualified flag missing");
  AST_QUAL_OFF: assert property ((!tone.guard_above)[*4] |-> !qualified_tone_flag) else $error("false flag");
  AST_RAW: assert property ((tone.raw_tone && !power_down)[*4] |-> raw_tone_flag) else $error("raw flag missing");
  AST_CARR: assert property ((demod.carrier && demod_enable && !power_down)[*4] |-> !carrier_present_n)
    else $error("carrier flag missing");
  AST_POWER_DOWN: assert property (power_down[*4] |-> !qualified_tone_flag && !raw_tone_flag)
    else $error("tone flags active in power down");
  AST_EVT_SET: assert property (event_sense_input[*4] |-> !event_sense_out_n) else $error("event missed");
  AST_EVT_HOLD: assert property ($rose(event_sense_out_n) |-> low_q >= HOLD_CYCLES) else $error("hold short");
endmodule // cidsp_checker

bind cidsp_top cidsp_checker #(.HOLD_CYCLES(HOLD_CYCLES)) cidsp_checker_inst (.*);

//--- verif/cidsp_mcu_model.sv
// Controller model reading words from the three-wire port.
`timescale 1ns/100ps
module cidsp_mcu_model (
  // Port as seen by the controller
  input wire logic shift_wire, mode_sel, data_ready_n, serial_data,
  // Controller clock and last word
  output logic mcu_clk,
  output logic [7:0] word
);
  // One edge while reset is held; the device drives the clock pin then, so the shift domain does not see it.
  initial begin
    mcu_clk = 1'b0;
    word = 8'h00;
    #40 mcu_clk = 1'b1;
    #16 mcu_clk = 1'b0;
  end
  // Data is settled by the falling edge in both modes, LSB first.
  always @(negedge shift_wire) begin
    word = {serial_data, word[7:1]};
  end
  // Eight edges per fresh ready in mode 1, clock at rest between words.
  always begin
    @(negedge data_ready_n);
    if (mode_sel) begin
      #7;
      repeat (8) begin
        mcu_clk = 1'b1;
        #16 mcu_clk = 1'b0;
        #16;
      end
    end
  end
endmodule // cidsp_mcu_model

//--- verif/test_callerid_serial_status_port.sv
// Self-checking bench for the serial and status port.
`timescale 1ns/100ps
module test_callerid_serial_status_port
  import cidsp_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic mode_sel = 1'b1;
  logic power_down = 1'b0;
  logic demod_enable = 1'b1;
  logic event_sense_input = 1'b0;
  cidsp_demod_type demod = '0;
  cidsp_tone_type tone = '0;
  logic shift_clk_in, mcu_clk, serial_shift_clock_o, serial_shift_clock_oe_n, serial_data, data_ready_n;
  logic carrier_present_n, raw_tone_flag, qualified_tone_flag, event_sense_out_n, event_request_o;
  logic event_request_oe_n, irq_n;
  logic [7:0] word;
  int err_count = 0;
  int samples_checked = 0;
  always #25 ref_clk = ~ref_clk;
  // Two-way clock pin, and the request line with its pull-up.
  assign shift_clk_in = serial_shift_clock_oe_n ? mcu_clk : serial_shift_clock_o;
  assign irq_n = event_request_oe_n ? 1'b1 : event_request_o;
  cidsp_top #(.HOLD_CYCLES(20)) cidsp_top_inst (.*);
  cidsp_mcu_model cidsp_mcu_model_inst (.shift_wire(shift_clk_in), .mode_sel(mode_sel), .data_ready_n(data_ready_n),
    .serial_data(serial_data), .mcu_clk(mcu_clk), .word(word));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic send(input logic [7:0] w, input int gap);
    for (int i = 0; i < WORD_BITS; i++) begin
      @(posedge ref_clk);
      demod.bit_valid <= 1'b1;
      demod.bit_value <= w[i];
      @(posedge ref_clk);
      demod.bit_valid <= 1'b0;
      idle(gap);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    idle(4);
    rst_b <= 1'b1;
    demod.carrier <= 1'b1;
    idle(8);
    chk(carrier_present_n, 1'b0);
    send(8'h3C, 4);
    idle(30);
    chk(word, 8'h3C);
    chk(data_ready_n, 1'b1);
    chk(irq_n, 1'b1);
    mode_sel <= 1'b0;
    idle(8);
    send(8'hA5, int'(HALF_BIT) + 8);
    chk(data_ready_n, 1'b0);
    chk(word, 8'hA5);
    chk(irq_n, 1'b0);
    mode_sel <= 1'b1;
    demod_enable <= 1'b0;
    idle(8);
    send(8'hFF, 4);
    idle(30);
    chk(data_ready_n, 1'b1);
    chk(word, 8'hA5);
    demod_enable <= 1'b1;
    power_down <= 1'b1;
    tone <= '1;
    event_sense_input <= 1'b1;
    idle(8);
    chk(qualified_tone_flag, 1'b0);
    chk(event_sense_out_n, 1'b0);
    chk(irq_n, 1'b0);
    power_down <= 1'b0;
    idle(8);
    chk(qualified_tone_flag, 1'b1);
    chk(raw_tone_flag, 1'b1);
    tone <= '0;
    event_sense_input <= 1'b0;
    idle(12);
    chk(event_sense_out_n, 1'b0);
    idle(40);
    chk(event_sense_out_n, 1'b1);
    chk(qualified_tone_flag, 1'b0);
    chk(irq_n, 1'b1);
    end_sim();
  end
  initial begin
    #5000000;
    err_count++;
    end_sim();
  end
endmodule // test_callerid_serial_status_port
